//--- shared/alarm_trim_pkg.sv
// Register map, field layout and carrier types for the alarm and trim block.
package alarm_trim_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 4;

   // Register offsets on the plain register port.
   localparam logic [ADDR_W-1:0] ADDR_ALARM_CONFIG = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_ALARM_WINDOW = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_CONFIG_TRIM = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h3;

   // Alarm configuration register fields.
   localparam int CFG_ENABLE_BIT = 15;
   localparam int CFG_ENDLESS_BIT = 14;
   localparam int CFG_INTERVAL_MSB = 13;
   localparam int CFG_INTERVAL_LSB = 10;
   localparam int CFG_PTR_MSB = 9;
   localparam int CFG_PTR_LSB = 8;
   localparam int CFG_REPEAT_MSB = 7;
   localparam int CFG_REPEAT_LSB = 0;

   // Configuration and trim register fields.
   localparam int TRIM_UNLOCK_BIT = 13;
   localparam int TRIM_VALUE_MSB = 7;
   localparam int TRIM_VALUE_LSB = 0;
   localparam int TRIM_MULT_SHIFT = 2;
   localparam int TRIM_PULSE_W = 10;

   // Status register fields.
   localparam int STAT_PULSE_BIT = 0;
   localparam int STAT_ROLLOVER_BIT = 1;
   localparam int STAT_ENABLE_BIT = 2;

   // Implemented bits of the three alarm value registers.
   localparam logic [DATA_W-1:0] MASK_MONTH_DATE = 16'h1f3f;
   localparam logic [DATA_W-1:0] MASK_WEEKDAY_HOUR = 16'h073f;
   localparam logic [DATA_W-1:0] MASK_MINUTE_SECOND = 16'h7f7f;

   // Digit masks used for matching.
   localparam logic [DATA_W-1:0] MASK_SEC_UNITS = 16'h000f;
   localparam logic [DATA_W-1:0] MASK_MIN_UNITS_SEC = 16'h0f7f;
   localparam logic [DATA_W-1:0] MASK_HOUR_FIELD = 16'h003f;
   localparam logic [DATA_W-1:0] MASK_WEEKDAY_FIELD = 16'h0700;

   // Window pointer codes.
   localparam logic [1:0] PTR_MONTH_DATE = 2'h2;
   localparam logic [1:0] PTR_WEEKDAY_HOUR = 2'h1;
   localparam logic [1:0] PTR_MINUTE_SECOND = 2'h0;

   // Interval select codes.
   localparam logic [3:0] IVL_HALF_SECOND = 4'h0;
   localparam logic [3:0] IVL_SECOND = 4'h1;
   localparam logic [3:0] IVL_TEN_SECONDS = 4'h2;
   localparam logic [3:0] IVL_MINUTE = 4'h3;
   localparam logic [3:0] IVL_TEN_MINUTES = 4'h4;
   localparam logic [3:0] IVL_HOUR = 4'h5;
   localparam logic [3:0] IVL_DAY = 4'h6;
   localparam logic [3:0] IVL_WEEK = 4'h7;
   localparam logic [3:0] IVL_MONTH = 4'h8;
   localparam logic [3:0] IVL_YEAR = 4'h9;

   localparam logic [7:0] REPEAT_ZERO = 8'h00;
   localparam logic [7:0] REPEAT_WRAP = 8'hff;
   localparam logic [7:0] REPEAT_STEP = 8'h01;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] month_date;
      logic [DATA_W-1:0] weekday_hour;
      logic [DATA_W-1:0] minute_second;
      logic second_half;
   } calendar_time_t;
endpackage : alarm_trim_pkg

//--- src/calendar_alarm_and_drift_trim.sv
// Alarm match, repeat counter, alarm pulse and per-minute drift trim of a BCD calendar.
//
// What this block does
// - Month/date alarm holds month tens bit 12, units 11-8, date tens 5-4, units 3-0.
// - Weekday/hour alarm holds weekday 10-8, hour tens 5-4, hour units 3-0.
// - Minute/second alarm holds minute tens 14-12, units 11-8, second tens 6-4, units 3-0.
// - Unimplemented alarm bits read zero; alarm digits are not reset.
// - Month/date and weekday/hour writes are taken only while the write unlock is set.
// - Once a minute the signed trim times four is issued as a pulse correction.
// - Negative trim removes timebase pulses, positive trim adds them.
// - The final alarm of a sequence clears the alarm enable.
// - Interval select chooses half second up to one year period.
// - Repeat count zero with endless off gives one alarm, then disables.
// - Each alarm decrements the repeat count; at zero a last alarm disables.
// - Repeat count FFh gives up to 255 more alarms after the first.
// - With endless repeat set the count wraps from 00h to FFh and continues.
// - Every alarm event raises an alarm interrupt request.
// - The alarm pulse output toggles on each alarm event.
// - Reserved interval codes never produce an alarm.
// - Yearly alarm on February 29 fires only every fourth year.
// - A window pointer selects the alarm value register and steps down to zero.
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
module calendar_alarm_and_drift_trim
   import alarm_trim_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire reg_req_t reg_req,
   output logic [DATA_W-1:0] reg_rdata,
   input wire calendar_time_t cal_time,
   input wire logic half_second_tick,
   input wire logic minute_tick,
   input wire logic rollover_window_flag,
   output logic alarm_irq,
   output logic alarm_pulse,
   output logic trim_apply,
   output logic signed [TRIM_PULSE_W-1:0] trim_pulses
);
   logic [DATA_W-1:0] alarm_month_date_value_reg;
   logic [DATA_W-1:0] alarm_weekday_hour_value_reg;
   logic [DATA_W-1:0] alarm_minute_second_value_reg;
   logic alarm_enable_reg;
   logic endless_repeat_reg;
   logic [3:0] alarm_interval_select_reg;
   logic [1:0] alarm_window_pointer_reg;
   logic [7:0] alarm_repeat_count_reg;
   logic clock_write_unlock_reg;
   logic [7:0] drift_trim_value_reg;
   logic [DATA_W-1:0] window_value;
   logic [DATA_W-1:0] cfg_value;
   logic [DATA_W-1:0] trim_value;
   logic [DATA_W-1:0] status_value;
   logic [DATA_W-1:0] read_next;
   logic cfg_wr;
   logic window_wr;
   logic window_access;
   logic trim_wr;
   logic alarm_match;
   logic alarm_event;
   logic final_alarm;

   assign cfg_wr = reg_req.wr && (reg_req.addr == ADDR_ALARM_CONFIG);
   assign window_wr = reg_req.wr && (reg_req.addr == ADDR_ALARM_WINDOW);
   assign window_access = (reg_req.wr || reg_req.rd) && (reg_req.addr == ADDR_ALARM_WINDOW);
   assign trim_wr = reg_req.wr && (reg_req.addr == ADDR_CONFIG_TRIM);

   always_ff @(posedge sys_clk)
   begin
      if (window_wr && clock_write_unlock_reg
          && alarm_window_pointer_reg == PTR_MONTH_DATE)
      begin
         alarm_month_date_value_reg <= reg_req.wdata & MASK_MONTH_DATE;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (window_wr && clock_write_unlock_reg
          && alarm_window_pointer_reg == PTR_WEEKDAY_HOUR)
      begin
         alarm_weekday_hour_value_reg <= reg_req.wdata & MASK_WEEKDAY_HOUR;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (window_wr && alarm_window_pointer_reg == PTR_MINUTE_SECOND)
      begin
         alarm_minute_second_value_reg <= reg_req.wdata & MASK_MINUTE_SECOND;
      end
   end

   // Interval and endless repeat settings.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         endless_repeat_reg <= 1'b0;
         alarm_interval_select_reg <= IVL_HALF_SECOND;
      end
      else if (cfg_wr)
      begin
         endless_repeat_reg <= reg_req.wdata[CFG_ENDLESS_BIT];
         alarm_interval_select_reg <= reg_req.wdata[CFG_INTERVAL_MSB:CFG_INTERVAL_LSB];
      end
   end

   // Window pointer load and step down.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         alarm_window_pointer_reg <= PTR_MINUTE_SECOND;
      end
      else if (cfg_wr)
      begin
         alarm_window_pointer_reg <= reg_req.wdata[CFG_PTR_MSB:CFG_PTR_LSB];
      end
      else if (window_access && alarm_window_pointer_reg != PTR_MINUTE_SECOND)
      begin
         alarm_window_pointer_reg <= alarm_window_pointer_reg - 2'h1;
      end
   end

   always_comb
   begin
      alarm_match = 1'b0;
      unique case (alarm_interval_select_reg)
         IVL_HALF_SECOND: alarm_match = 1'b1;
         IVL_SECOND: alarm_match = !cal_time.second_half;
         IVL_TEN_SECONDS: alarm_match = !cal_time.second_half
            && ((cal_time.minute_second & MASK_SEC_UNITS)
                == (alarm_minute_second_value_reg & MASK_SEC_UNITS));
         IVL_MINUTE: alarm_match = !cal_time.second_half
            && ((cal_time.minute_second & MASK_MINUTE_SECOND[7:0])
                == (alarm_minute_second_value_reg & MASK_MINUTE_SECOND[7:0]));
         IVL_TEN_MINUTES: alarm_match = !cal_time.second_half
            && ((cal_time.minute_second & MASK_MIN_UNITS_SEC)
                == (alarm_minute_second_value_reg & MASK_MIN_UNITS_SEC));
         IVL_HOUR: alarm_match = !cal_time.second_half
            && (cal_time.minute_second == alarm_minute_second_value_reg);
         IVL_DAY: alarm_match = !cal_time.second_half
            && (cal_time.minute_second == alarm_minute_second_value_reg)
            && ((cal_time.weekday_hour & MASK_HOUR_FIELD)
                == (alarm_weekday_hour_value_reg & MASK_HOUR_FIELD));
         IVL_WEEK: alarm_match = !cal_time.second_half
            && (cal_time.minute_second == alarm_minute_second_value_reg)
            && (cal_time.weekday_hour == alarm_weekday_hour_value_reg);
         IVL_MONTH: alarm_match = !cal_time.second_half
            && (cal_time.minute_second == alarm_minute_second_value_reg)
            && ((cal_time.weekday_hour & MASK_HOUR_FIELD)
                == (alarm_weekday_hour_value_reg & MASK_HOUR_FIELD))
            && ((cal_time.month_date & MASK_HOUR_FIELD)
                == (alarm_month_date_value_reg & MASK_HOUR_FIELD));
         // Full date match makes February 29 a leap-year event.
         IVL_YEAR: alarm_match = !cal_time.second_half
            && (cal_time.minute_second == alarm_minute_second_value_reg)
            && ((cal_time.weekday_hour & MASK_HOUR_FIELD)
                == (alarm_weekday_hour_value_reg & MASK_HOUR_FIELD))
            && (cal_time.month_date == alarm_month_date_value_reg);
         default: alarm_match = 1'b0;
      endcase
   end

   assign alarm_event = half_second_tick && alarm_enable_reg && alarm_match;
   assign final_alarm = (alarm_repeat_count_reg == REPEAT_ZERO) && !endless_repeat_reg;

   // Enable cleared by the final alarm.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         alarm_enable_reg <= 1'b0;
      end
      else if (alarm_event && final_alarm)
      begin
         alarm_enable_reg <= 1'b0;
      end
      else if (cfg_wr)
      begin
         alarm_enable_reg <= reg_req.wdata[CFG_ENABLE_BIT];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         alarm_repeat_count_reg <= REPEAT_ZERO;
      end
      else if (alarm_event)
      begin
         if (alarm_repeat_count_reg != REPEAT_ZERO)
         begin
            alarm_repeat_count_reg <= alarm_repeat_count_reg - REPEAT_STEP;
         end
         else if (endless_repeat_reg)
         begin
            alarm_repeat_count_reg <= REPEAT_WRAP;
         end
      end
      else if (cfg_wr)
      begin
         alarm_repeat_count_reg <= reg_req.wdata[CFG_REPEAT_MSB:CFG_REPEAT_LSB];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         alarm_irq <= 1'b0;
      end
      else
      begin
         alarm_irq <= alarm_event;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         alarm_pulse <= 1'b0;
      end
      else if (alarm_event)
      begin
         alarm_pulse <= !alarm_pulse;
      end
   end

   // Write unlock and trim value.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         clock_write_unlock_reg <= 1'b0;
         drift_trim_value_reg <= REPEAT_ZERO;
      end
      else if (trim_wr)
      begin
         clock_write_unlock_reg <= reg_req.wdata[TRIM_UNLOCK_BIT];
         drift_trim_value_reg <= reg_req.wdata[TRIM_VALUE_MSB:TRIM_VALUE_LSB];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         trim_apply <= 1'b0;
         trim_pulses <= '0;
      end
      else
      begin
         trim_apply <= minute_tick;
         if (minute_tick)
         begin
            // Sign kept, so negative removes pulses.
            trim_pulses <= TRIM_PULSE_W'($signed(drift_trim_value_reg)) <<< TRIM_MULT_SHIFT;
         end
      end
   end

   // Window selection with zero for unimplemented slot.
   always_comb
   begin
      unique case (alarm_window_pointer_reg)
         PTR_MONTH_DATE: window_value = alarm_month_date_value_reg;
         PTR_WEEKDAY_HOUR: window_value = alarm_weekday_hour_value_reg;
         PTR_MINUTE_SECOND: window_value = alarm_minute_second_value_reg;
         default: window_value = '0;
      endcase
   end

   always_comb
   begin
      cfg_value = '0;
      cfg_value[CFG_ENABLE_BIT] = alarm_enable_reg;
      cfg_value[CFG_ENDLESS_BIT] = endless_repeat_reg;
      cfg_value[CFG_INTERVAL_MSB:CFG_INTERVAL_LSB] = alarm_interval_select_reg;
      cfg_value[CFG_PTR_MSB:CFG_PTR_LSB] = alarm_window_pointer_reg;
      cfg_value[CFG_REPEAT_MSB:CFG_REPEAT_LSB] = alarm_repeat_count_reg;
      trim_value = '0;
      trim_value[TRIM_UNLOCK_BIT] = clock_write_unlock_reg;
      trim_value[TRIM_VALUE_MSB:TRIM_VALUE_LSB] = drift_trim_value_reg;
      status_value = '0;
      status_value[STAT_PULSE_BIT] = alarm_pulse;
      status_value[STAT_ROLLOVER_BIT] = rollover_window_flag;
      status_value[STAT_ENABLE_BIT] = alarm_enable_reg;
   end

   always_comb
   begin
      unique case (reg_req.addr)
         ADDR_ALARM_CONFIG: read_next = cfg_value;
         ADDR_ALARM_WINDOW: read_next = window_value;
         ADDR_CONFIG_TRIM: read_next = trim_value;
         ADDR_STATUS: read_next = status_value;
         default: read_next = '0;
      endcase
   end

   // Read data one cycle after the strobe, zero otherwise.
   always_ff @(posedge sys_clk)
   begin
      if (reset || !reg_req.rd)
      begin
         reg_rdata <= '0;
      end
      else
      begin
         reg_rdata <= read_next;
      end
   end
endmodule : calendar_alarm_and_drift_trim

//--- sim/alarm_trim_checker.sv
// Port checks for the alarm and drift trim block.
`timescale 1ns/1ns
module alarm_trim_checker
   import alarm_trim_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire reg_req_t reg_req,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic half_second_tick,
   input wire logic minute_tick,
   input wire logic alarm_irq,
   input wire logic alarm_pulse,
   input wire logic trim_apply,
   input wire logic signed [TRIM_PULSE_W-1:0] trim_pulses
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   window_unimpl_a: assert property (
      $past(reg_req.rd) && $past(reg_req.addr) == ADDR_ALARM_WINDOW
      |-> (reg_rdata & ~MASK_MINUTE_SECOND) == '0) else $error("window spare bits set");
   unmapped_zero_a: assert property (
      $past(reg_req.rd) && $past(reg_req.addr) > ADDR_STATUS |-> reg_rdata == '0)
      else $error("unmapped read not zero");
   irq_on_tick_a: assert property (
      alarm_irq |-> $past(half_second_tick)) else $error("alarm without tick");
   irq_single_a: assert property (
      alarm_irq |=> !alarm_irq) else $error("alarm request too long");
   pulse_follows_irq_a: assert property (
      !$past(reset) |-> ((alarm_pulse != $past(alarm_pulse)) == alarm_irq))
      else $error("pulse toggle and alarm disagree");
   trim_timing_a: assert property (
      trim_apply == $past(minute_tick)) else $error("trim apply mistimed");
   trim_scale_a: assert property (
      trim_apply |-> trim_pulses[1:0] == 2'b00) else $error("trim not times four");
   trim_hold_a: assert property (
      !trim_apply && !$past(reset) |-> $stable(trim_pulses)) else $error("trim moved");

   cover property (alarm_irq);
   cover property (trim_apply && trim_pulses < 0);
   cover property ($past(reg_req.rd) && $past(reg_req.addr) == ADDR_ALARM_WINDOW);
endmodule : alarm_trim_checker

bind calendar_alarm_and_drift_trim alarm_trim_checker u_chk (
   .sys_clk(sys_clk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
   .half_second_tick(half_second_tick), .minute_tick(minute_tick), .alarm_irq(alarm_irq),
   .alarm_pulse(alarm_pulse), .trim_apply(trim_apply), .trim_pulses(trim_pulses));

//--- sim/testbench.sv
// Self-checking bench for the alarm and drift trim block.
`timescale 1ns/1ns
module testbench;
   import alarm_trim_pkg::*;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   reg_req_t req = '0;
   calendar_time_t cal = '0;
   logic hst = 1'b0;
   logic mt = 1'b0;
   logic roll = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic irq;
   logic pulse;
   logic tapp;
   logic signed [TRIM_PULSE_W-1:0] tpul;
   int failures = 0;
   int n_checks = 0;
   int n_irq = 0;
   int base;
   int tvx;
   logic [15:0] win [3] = '{16'h1f3f, 16'h073f, 16'h7f7f};
   logic [15:0] cmd [4] = '{16'h1f3f, 16'h1f3f, 16'h0f3f, 16'h1f3f};
   logic [15:0] cms [4] = '{16'h0000, 16'h0010, 16'h0000, 16'h0000};
   int lim [4] = '{10, 3, 9, 1};
   logic [7:0] tv8 [4] = '{8'h7f, 8'h80, 8'hfd, 8'h01};

   always #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (irq === 1'b1) n_irq <= n_irq + 1;

   calendar_alarm_and_drift_trim u_dut (
      .sys_clk(sys_clk), .reset(reset), .reg_req(req), .reg_rdata(rdata), .cal_time(cal),
      .half_second_tick(hst), .minute_tick(mt), .rollover_window_flag(roll),
      .alarm_irq(irq), .alarm_pulse(pulse), .trim_apply(tapp), .trim_pulses(tpul));

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      req <= {a, d, 2'b10};
      @(posedge sys_clk);
      req.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
      @(posedge sys_clk);
      req <= {a, 16'h0000, 2'b01};
      @(posedge sys_clk);
      req.rd <= 1'b0;
      #1 chk(nm, e, rdata);
   endtask : rd

   task automatic win_read();
      wr(ADDR_ALARM_CONFIG, 16'h0200);
      for (int i = 0; i < 3; i++)
         rd(ADDR_ALARM_WINDOW, win[i], "window value");
      rd(ADDR_ALARM_WINDOW, win[2], "pointer floor");
   endtask : win_read

   task automatic tick();
      @(posedge sys_clk);
      hst <= 1'b1;
      @(posedge sys_clk);
      hst <= 1'b0;
      @(posedge sys_clk);
      #1;
   endtask : tick

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : final_report

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      final_report();
   end

   initial
   begin
      repeat (12) @(posedge sys_clk);
      reset <= 1'b0;
      rd(ADDR_ALARM_CONFIG, 16'h0000, "config reset");
      rd(4'hf, 16'h0000, "unmapped");
      wr(ADDR_ALARM_CONFIG, 16'h0300);
      rd(ADDR_ALARM_WINDOW, 16'h0000, "window spare");
      rd(ADDR_ALARM_CONFIG, 16'h0200, "pointer step");
      $display("test reset done");
      wr(ADDR_CONFIG_TRIM, 16'h2000);
      wr(ADDR_ALARM_CONFIG, 16'h0200);
      repeat (3) wr(ADDR_ALARM_WINDOW, 16'hffff);
      win_read();
      wr(ADDR_CONFIG_TRIM, 16'h0000);
      wr(ADDR_ALARM_CONFIG, 16'h0200);
      repeat (3) wr(ADDR_ALARM_WINDOW, 16'h0000);
      win[2] = 16'h0000;
      win_read();
      $display("test window done");
      cal <= {16'h1f3f, 16'h073f, 16'h0000, 1'b0};
      wr(ADDR_ALARM_CONFIG, 16'h8001);
      tick();
      chk("pulse level", 16'h0001, {15'h0, pulse});
      tick();
      tick();
      chk("repeat alarms", 16'h0002, n_irq[15:0]);
      rd(ADDR_ALARM_CONFIG, 16'h0000, "final disable");
      wr(ADDR_ALARM_CONFIG, 16'hc000);
      tick();
      rd(ADDR_ALARM_CONFIG, 16'hc0ff, "wrap");
      tick();
      rd(ADDR_ALARM_CONFIG, 16'hc0fe, "count on");
      wr(ADDR_ALARM_CONFIG, 16'h80ff);
      tick();
      rd(ADDR_ALARM_CONFIG, 16'h80fe, "full load");
      wr(ADDR_ALARM_CONFIG, 16'h0000);
      roll <= 1'b1;
      rd(ADDR_STATUS, 16'h0003, "status");
      roll <= 1'b0;
      $display("test repeat done");
      for (int p = 0; p < 4; p++)
      begin
         cal <= {cmd[p], 16'h073f, cms[p], (p == 3) ? 1'b1 : 1'b0};
         for (int c = 0; c < 16; c++)
         begin
            base = n_irq;
            wr(ADDR_ALARM_CONFIG, {1'b1, 1'b0, c[3:0], 10'h000});
            tick();
            chk("interval", {15'h0, c < lim[p]}, 16'(n_irq - base));
            wr(ADDR_ALARM_CONFIG, 16'h0000);
         end
      end
      $display("test interval done");
      for (int k = 0; k < 4; k++)
      begin
         wr(ADDR_CONFIG_TRIM, {8'h00, tv8[k]});
         @(posedge sys_clk);
         mt <= 1'b1;
         @(posedge sys_clk);
         mt <= 1'b0;
         tvx = $signed(tv8[k]) * 4;
         #1 chk("trim apply", 16'h0001, {15'h0, tapp});
         chk("trim pulses", {6'h00, tvx[9:0]}, {6'h00, tpul});
      end
      $display("test trim done");
      final_report();
   end
endmodule : testbench
